// ---- hw/spm_pkg.sv ----
// Package: constants, types and mode decoding for the SPI master port
`default_nettype none
package spm_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned FAULT_TIME_MS = 2300;
   localparam int unsigned FAULT_CYCLES = FAULT_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned WRITE_WAIT_MS = 5;
   localparam int unsigned WRITE_WAIT_CYCLES = WRITE_WAIT_MS * (CLK_HZ / 1000);

   // ------------------------------------------------------------
   // Bit clock half periods in system clocks
   // ------------------------------------------------------------
   localparam logic [5:0] HALF_FAST = 6'h02;
   localparam logic [5:0] HALF_MEDIUM = 6'h08;
   localparam logic [5:0] HALF_SLOW = 6'h20;

   // ------------------------------------------------------------
   // Bytes and levels
   // ------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] RX_FILL = 8'h00;
   localparam logic SDI_IDLE_LEVEL = 1'b1;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] LAST_BYTE = 3'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SPEED_FAST = 2'h0,
      SPEED_MEDIUM = 2'h1,
      SPEED_SLOW = 2'h2
   } spm_speed_e;

   // Bit 2 late sample, bit 1 idle high, bit 0 edge b
   typedef enum logic [2:0] {
      idle_low_edge_a_mid = 3'h0,
      idle_low_edge_b_mid = 3'h1,
      idle_high_edge_a_mid = 3'h2,
      idle_high_edge_b_mid = 3'h3,
      idle_low_edge_a_late = 3'h4,
      idle_low_edge_b_late = 3'h5,
      idle_high_edge_a_late = 3'h6,
      idle_high_edge_b_late = 3'h7
   } spm_mode_e;

   typedef struct packed {
      logic clock_idle_polarity;
      logic clock_edge_select;
      logic input_sample_point;
      logic [5:0] half;
   } spm_cfg_s;

   typedef struct packed {
      logic off;
      spm_mode_e mode;
      spm_speed_e speed;
   } spm_setup_s;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } spm_mem_s;

   // Turn a setup request into the working configuration
   function automatic spm_cfg_s decode_setup(spm_setup_s s);
      spm_cfg_s c;
      c.clock_idle_polarity = s.mode[1];
      c.clock_edge_select = ~s.mode[0];
      c.input_sample_point = s.mode[2];
      case (s.speed)
         SPEED_FAST: c.half = HALF_FAST;
         SPEED_MEDIUM: c.half = HALF_MEDIUM;
         default: c.half = HALF_SLOW;
      endcase
      return c;
   endfunction

endpackage
`default_nettype wire

// ---- hw/spm_port.sv ----
// SPI master port: setup, byte transmit/receive and memory sequencer
// ------------------------------------------------------------
// How it works
// - A receive request clocks one byte in and hands it back, one per request.
// - Transmit requests clock their bytes out one after another in order.
// - No transmit or receive is taken before a setup has enabled the port.
// - A transmit starts only while the input pin sits at its idle level.
// - A wrong input level at transmit start raises the fault flag by itself.
// - A fault lasting 2.3 s pulses a device reset and resets the port.
// - Idle-low modes use polarity 0, edge a sets edge select 1, edge b 0.
// - Idle-high modes use polarity 1, edge a sets edge select 1, edge b 0.
// - Mid variants sample in the middle of the data time, late ones at its end.
// - The bit clock is the system clock divided by 4, 16 or 64.
// - Serial out goes to the peripheral input, its output to serial in.
// - A memory write sends write enable in one frame, then 2, address, data.
// - After a memory write frame ends the sequencer waits 5 ms.
// - A memory read sends 3 and the address, then shifts in the data byte.
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module spm_port #(
   parameter int unsigned FAULT_CYCLES = spm_pkg::FAULT_CYCLES,
   parameter int unsigned WRITE_WAIT_CYCLES = spm_pkg::WRITE_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Setup request
   input wire logic setup_valid,
   input wire spm_pkg::spm_setup_s setup_req,
   output logic setup_ready,
   output logic port_enabled,
   // Byte request and answer
   input wire logic cmd_valid,
   input wire logic cmd_rx,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   // Memory request and answer
   input wire logic mem_valid,
   input wire spm_pkg::spm_mem_s mem_req,
   output logic mem_ready,
   output logic mem_rdata_valid,
   output logic [7:0] mem_rdata,
   output logic mem_select_n,
   // Fault reporting
   output logic spi_fault,
   output logic device_reset,
   // SPI pins
   output logic sck_o,
   output logic sck_oe,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   input wire logic serial_data_in
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      E_IDLE = 2'h0,
      E_A = 2'h1,
      E_B = 2'h3
   } spm_eng_e;

   typedef enum logic [2:0] {
      SQ_IDLE = 3'h0,
      SQ_WREN = 3'h1,
      SQ_GAP = 3'h3,
      SQ_WR = 3'h2,
      SQ_WAIT = 3'h6,
      SQ_RD = 3'h7
   } spm_seq_e;

   logic sdi_meta_ff, sdi_ff;
   logic en_ff;
   spm_pkg::spm_cfg_s cfg_ff;
   spm_eng_e e_state_ff;
   logic [5:0] hcnt_ff;
   logic [2:0] bit_ff;
   logic [7:0] tx_sh_ff, rx_sh_ff, rx_byte_ff;
   logic sck_ff, sdo_ff, done_ff, owner_seq_ff;
   spm_seq_e sq_ff;
   spm_pkg::spm_mem_s mem_ff;
   logic [2:0] idx_ff;
   logic [31:0] wait_ff, fault_cnt_ff;
   logic fault_ff, dev_rst_ff;
   logic [7:0] rdata_ff;
   logic rdata_v_ff;
   logic rsp_v_ff;
   logic [7:0] rsp_ff;
   logic cs_n_ff;

   logic srst, sdi_ok, eng_free, seq_go, seq_rx, user_ok, go, go_rx;
   logic accept, tx_blocked;
   logic [7:0] go_byte, seq_byte, nxt_rx_sh;

   // Port reset also taken on a persistent fault
   assign srst = rst | dev_rst_ff;

   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------
   // Two stages before the input pin is used
   always_ff @(posedge clock) begin
      sdi_meta_ff <= serial_data_in;
      sdi_ff <= sdi_meta_ff;
   end

   assign sdi_ok = (sdi_ff == spm_pkg::SDI_IDLE_LEVEL);

   // ------------------------------------------------------------
   // Setup
   // ------------------------------------------------------------
   assign setup_ready = eng_free && (sq_ff == SQ_IDLE);

   // Enable and configuration
   always_ff @(posedge clock) begin
      if (srst) begin
         en_ff <= 1'b0;
         cfg_ff <= '0;
      end else if (setup_valid && setup_ready) begin
         en_ff <= ~setup_req.off;
         if (!setup_req.off) begin
            cfg_ff <= spm_pkg::decode_setup(setup_req);
         end
      end
   end

   assign port_enabled = en_ff;

   // ------------------------------------------------------------
   // Request arbitration
   // ------------------------------------------------------------
   assign eng_free = (e_state_ff == E_IDLE) && !done_ff;
   assign user_ok = en_ff && eng_free && (sq_ff == SQ_IDLE) && !mem_valid;
   assign cmd_ready = user_ok && (cmd_rx || sdi_ok);
   assign seq_go = en_ff && eng_free
      && ((sq_ff == SQ_WREN) || (sq_ff == SQ_WR) || (sq_ff == SQ_RD));
   assign seq_rx = (sq_ff == SQ_RD) && (idx_ff == spm_pkg::LAST_BYTE);

   // Byte the sequencer wants next
   always_comb begin
      seq_byte = spm_pkg::RX_FILL;
      case (idx_ff)
         3'h0: begin
            if (sq_ff == SQ_WREN) begin
               seq_byte = spm_pkg::OP_WRITE_ENABLE;
            end else if (sq_ff == SQ_WR) begin
               seq_byte = spm_pkg::OP_WRITE;
            end else begin
               seq_byte = spm_pkg::OP_READ;
            end
         end
         3'h1: seq_byte = mem_ff.addr[15:8];
         3'h2: seq_byte = mem_ff.addr[7:0];
         3'h3: seq_byte = (sq_ff == SQ_WR) ? mem_ff.wdata : spm_pkg::RX_FILL;
         default: seq_byte = spm_pkg::RX_FILL;
      endcase
   end

   assign go = seq_go || (cmd_valid && user_ok);
   assign go_rx = seq_go ? seq_rx : cmd_rx;
   assign go_byte = seq_go ? seq_byte : (cmd_rx ? spm_pkg::RX_FILL : cmd_data);
   assign tx_blocked = go && !go_rx && !sdi_ok;
   assign accept = go && !tx_blocked;

   // ------------------------------------------------------------
   // Byte engine
   // ------------------------------------------------------------
   assign nxt_rx_sh = {rx_sh_ff[6:0], sdi_ff};

   // Shifter, bit clock and sample points
   always_ff @(posedge clock) begin
      if (srst) begin
         e_state_ff <= E_IDLE;
         hcnt_ff <= '0;
         bit_ff <= '0;
         tx_sh_ff <= '0;
         rx_sh_ff <= '0;
         rx_byte_ff <= '0;
         sck_ff <= 1'b0;
         sdo_ff <= 1'b0;
         done_ff <= 1'b0;
         owner_seq_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         case (e_state_ff)
            E_IDLE: begin
               sck_ff <= cfg_ff.clock_idle_polarity;
               if (accept) begin
                  owner_seq_ff <= seq_go;
                  tx_sh_ff <= go_byte;
                  sdo_ff <= go_byte[7];
                  sck_ff <= cfg_ff.clock_edge_select ? cfg_ff.clock_idle_polarity
                     : ~cfg_ff.clock_idle_polarity;
                  hcnt_ff <= cfg_ff.half - 6'h01;
                  bit_ff <= spm_pkg::LAST_BIT;
                  e_state_ff <= E_A;
               end
            end
            E_A: begin
               if (hcnt_ff == 6'h00) begin
                  if (!cfg_ff.input_sample_point) begin
                     rx_sh_ff <= nxt_rx_sh;
                  end
                  sck_ff <= ~sck_ff;
                  hcnt_ff <= cfg_ff.half - 6'h01;
                  e_state_ff <= E_B;
               end else begin
                  hcnt_ff <= hcnt_ff - 6'h01;
               end
            end
            E_B: begin
               if (hcnt_ff == 6'h00) begin
                  if (cfg_ff.input_sample_point) begin
                     rx_sh_ff <= nxt_rx_sh;
                  end
                  hcnt_ff <= cfg_ff.half - 6'h01;
                  if (bit_ff == 3'h0) begin
                     rx_byte_ff <= cfg_ff.input_sample_point ? nxt_rx_sh : rx_sh_ff;
                     sck_ff <= cfg_ff.clock_idle_polarity;
                     done_ff <= 1'b1;
                     e_state_ff <= E_IDLE;
                  end else begin
                     bit_ff <= bit_ff - 3'h1;
                     tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                     sdo_ff <= tx_sh_ff[6];
                     sck_ff <= ~sck_ff;
                     e_state_ff <= E_A;
                  end
               end else begin
                  hcnt_ff <= hcnt_ff - 6'h01;
               end
            end
            default: e_state_ff <= E_IDLE;
         endcase
      end
   end

   // Pins released while the port is off
   assign sck_o = sck_ff;
   assign serial_data_out = sdo_ff;
   assign sck_oe = en_ff;
   assign serial_data_out_oe = en_ff;

   // ------------------------------------------------------------
   // User byte answer
   // ------------------------------------------------------------
   // One answer per finished user byte
   always_ff @(posedge clock) begin
      if (srst) begin
         rsp_v_ff <= 1'b0;
         rsp_ff <= '0;
      end else begin
         rsp_v_ff <= done_ff && !owner_seq_ff;
         if (done_ff && !owner_seq_ff) begin
            rsp_ff <= rx_byte_ff;
         end
      end
   end

   assign rsp_valid = rsp_v_ff;
   assign rsp_data = rsp_ff;

   // ------------------------------------------------------------
   // Memory sequencer
   // ------------------------------------------------------------
   assign mem_ready = en_ff && (sq_ff == SQ_IDLE) && eng_free;

   // Frames, byte index, select and write wait
   always_ff @(posedge clock) begin
      if (srst) begin
         sq_ff <= SQ_IDLE;
         mem_ff <= '0;
         idx_ff <= '0;
         wait_ff <= '0;
         cs_n_ff <= 1'b1;
         rdata_ff <= '0;
         rdata_v_ff <= 1'b0;
      end else begin
         rdata_v_ff <= 1'b0;
         case (sq_ff)
            SQ_IDLE: begin
               idx_ff <= '0;
               if (mem_valid && mem_ready) begin
                  mem_ff <= mem_req;
                  cs_n_ff <= 1'b0;
                  sq_ff <= mem_req.write ? SQ_WREN : SQ_RD;
               end
            end
            SQ_WREN: begin
               if (done_ff) begin
                  cs_n_ff <= 1'b1;
                  sq_ff <= SQ_GAP;
               end
            end
            SQ_GAP: begin
               cs_n_ff <= 1'b0;
               sq_ff <= SQ_WR;
            end
            SQ_WR: begin
               if (done_ff) begin
                  idx_ff <= idx_ff + 3'h1;
                  if (idx_ff == spm_pkg::LAST_BYTE) begin
                     cs_n_ff <= 1'b1;
                     wait_ff <= '0;
                     sq_ff <= SQ_WAIT;
                  end
               end
            end
            SQ_WAIT: begin
               if (wait_ff == WRITE_WAIT_CYCLES - 1) begin
                  sq_ff <= SQ_IDLE;
               end else begin
                  wait_ff <= wait_ff + 32'h1;
               end
            end
            SQ_RD: begin
               if (done_ff) begin
                  idx_ff <= idx_ff + 3'h1;
                  if (idx_ff == spm_pkg::LAST_BYTE) begin
                     cs_n_ff <= 1'b1;
                     rdata_ff <= rx_byte_ff;
                     rdata_v_ff <= 1'b1;
                     sq_ff <= SQ_IDLE;
                  end
               end
            end
            default: sq_ff <= SQ_IDLE;
         endcase
      end
   end

   assign mem_rdata = rdata_ff;
   assign mem_rdata_valid = rdata_v_ff;
   assign mem_select_n = cs_n_ff;

   // ------------------------------------------------------------
   // Fault watch
   // ------------------------------------------------------------
   // Count cycles of a blocked transmit, reset on overrun
   always_ff @(posedge clock) begin
      if (rst || dev_rst_ff) begin
         fault_ff <= 1'b0;
         fault_cnt_ff <= '0;
         dev_rst_ff <= 1'b0;
      end else begin
         fault_ff <= tx_blocked;
         if (!tx_blocked) begin
            fault_cnt_ff <= '0;
         end else if (fault_cnt_ff == FAULT_CYCLES - 1) begin
            dev_rst_ff <= 1'b1;
         end else begin
            fault_cnt_ff <= fault_cnt_ff + 32'h1;
         end
      end
   end

   assign spi_fault = fault_ff;
   assign device_reset = dev_rst_ff;

endmodule
`default_nettype wire

// ---- testbench/spm_port_asserts.sv ----
// Assertion checker for the SPI master port
`timescale 1ns/1ps
`default_nettype none
module spm_port_asserts #(
   parameter int unsigned FAULT_CYCLES = 50
) (
   // Clock, reset and requests
   input wire logic clock,
   input wire logic rst,
   input wire logic setup_valid,
   input wire spm_pkg::spm_setup_s setup_req,
   input wire logic setup_ready,
   input wire logic cmd_valid,
   input wire logic cmd_rx,
   input wire logic cmd_ready,
   input wire logic mem_ready,
   // Status and pins
   input wire logic port_enabled,
   input wire logic rsp_valid,
   input wire logic spi_fault,
   input wire logic device_reset,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic serial_data_out_oe,
   input wire logic serial_data_in
);
   // ------
   // Helpers
   // ------
   logic pol_ff;
   logic [9:0] exp_ff;
   logic [9:0] tcnt_ff;
   logic [31:0] fcnt_ff;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Idle level and byte time of the last setup
   always_ff @(posedge clock) begin
      if (setup_valid && setup_ready) begin
         pol_ff <= setup_req.mode[1];
         exp_ff <= (setup_req.speed == spm_pkg::SPEED_FAST) ? 10'h022 :
            (setup_req.speed == spm_pkg::SPEED_MEDIUM) ? 10'h082 : 10'h202;
      end
   end
   // Cycles since a byte was taken
   always_ff @(posedge clock) begin
      if (rst) tcnt_ff <= 10'h000;
      else if (cmd_valid && cmd_ready) tcnt_ff <= 10'h001;
      else if (rsp_valid) tcnt_ff <= 10'h000;
      else if (tcnt_ff != 10'h000) tcnt_ff <= tcnt_ff + 10'h001;
   end
   // Length of the running fault
   always_ff @(posedge clock) begin
      if (rst || device_reset || !spi_fault) fcnt_ff <= 32'h0;
      else fcnt_ff <= fcnt_ff + 32'h1;
   end
   // ------
   // Properties
   // ------
   AST_CMD_NEEDS_SETUP: assert property (!port_enabled |-> !cmd_ready)
      else $error("byte request open while port off");
   AST_MEM_NEEDS_SETUP: assert property (!port_enabled |-> !mem_ready)
      else $error("memory request open while port off");
   AST_TX_IDLE_LEVEL: assert property (
      cmd_valid && cmd_ready && !cmd_rx |-> $past(serial_data_in, 2))
      else $error("transmit taken with input off idle level");
   AST_FAULT_CAUSE: assert property (
      $rose(spi_fault) |-> $past(cmd_valid && !cmd_rx && !cmd_ready))
      else $error("fault without a held back transmit");
   AST_FAULT_TIMEOUT: assert property (
      $rose(device_reset) |-> fcnt_ff + 3 >= FAULT_CYCLES && fcnt_ff <= FAULT_CYCLES + 3)
      else $error("device reset at wrong fault length");
   AST_RESET_DISABLES: assert property (device_reset |=> !port_enabled)
      else $error("port still on after device reset");
   AST_BYTE_TIME: assert property (
      rsp_valid |-> tcnt_ff >= exp_ff && tcnt_ff <= exp_ff + 10'h001)
      else $error("byte time does not match divider");
   AST_IDLE_POLARITY: assert property (rsp_valid |-> sck_o == pol_ff)
      else $error("clock not at idle level after byte");
   AST_PINS_RELEASED: assert property (
      !port_enabled [*2] |-> !sck_oe && !serial_data_out_oe)
      else $error("pins driven while port off");
   COV_BYTE: cover property (rsp_valid);
   COV_FAULT_RESET: cover property (device_reset);
   COV_SETUP: cover property (setup_valid && setup_ready);
endmodule
bind spm_port spm_port_asserts #(.FAULT_CYCLES(FAULT_CYCLES)) u_chk (.clock(clock), .rst(rst),
   .setup_valid(setup_valid), .setup_req(setup_req), .setup_ready(setup_ready),
   .cmd_valid(cmd_valid), .cmd_rx(cmd_rx), .cmd_ready(cmd_ready), .mem_ready(mem_ready),
   .port_enabled(port_enabled), .rsp_valid(rsp_valid), .spi_fault(spi_fault),
   .device_reset(device_reset), .sck_o(sck_o), .sck_oe(sck_oe),
   .serial_data_out_oe(serial_data_out_oe), .serial_data_in(serial_data_in));
`default_nettype wire

// ---- testbench/spm_peer_model.sv ----
// SPI memory peripheral model on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module spm_peer_model (
   // Clock, realign and mode
   input wire logic clock,
   input wire logic rst,
   input wire spm_pkg::spm_mode_e mode,
   // Bench controls
   input wire logic user_sel,
   input wire logic bad_idle,
   input wire logic [7:0] user_byte,
   // SPI pins
   input wire logic sck,
   input wire logic select_n,
   input wire logic mosi,
   output logic miso
);
   logic prev_ff, wel_ff, samp;
   logic [2:0] bit_ff, obit_ff, nbyte_ff;
   logic [7:0] sr_ff, op_ff, got_ff, got_prev_ff, nxt_sr;
   logic [15:0] addr_ff;
   logic [7:0] mem [0:255];
   // Edge a samples leaving idle, edge b returning
   assign samp = (sck != prev_ff) && ((sck != mode[1]) == !mode[0]);
   assign nxt_sr = {sr_ff[6:0], mosi};
   // Shift in and decode frames
   always_ff @(posedge clock) begin
      prev_ff <= sck;
      if (select_n) nbyte_ff <= 3'h0;
      if (rst) begin
         bit_ff <= 3'h0;
         obit_ff <= 3'h0;
         wel_ff <= 1'b0;
      end else if (samp) begin
         bit_ff <= bit_ff + 3'h1;
         sr_ff <= nxt_sr;
         if (bit_ff == 3'h7) begin
            got_prev_ff <= got_ff;
            got_ff <= nxt_sr;
            if (!select_n) begin
               nbyte_ff <= nbyte_ff + 3'h1;
               if (nbyte_ff == 3'h0) op_ff <= nxt_sr;
               if (nbyte_ff == 3'h0 && nxt_sr == 8'h06) wel_ff <= 1'b1;
               if (nbyte_ff == 3'h1) addr_ff[15:8] <= nxt_sr;
               if (nbyte_ff == 3'h2) addr_ff[7:0] <= nxt_sr;
               if (nbyte_ff == 3'h3 && op_ff == 8'h02 && wel_ff) begin
                  mem[addr_ff[7:0]] <= nxt_sr;
                  wel_ff <= 1'b0;
               end
            end
         end
      end else if (sck != prev_ff) begin
         obit_ff <= bit_ff; // Output moves on the edge opposite the sample
      end
   end
   // Held low on bad_idle, else read data or user byte, else pulled up
   always_comb begin
      if (bad_idle) miso = 1'b0;
      else if (!select_n && op_ff == 8'h03 && nbyte_ff == 3'h3) miso = mem[addr_ff[7:0]][~obit_ff];
      else if (user_sel) miso = user_byte[~obit_ff];
      else miso = 1'b1;
   end
endmodule
`default_nettype wire

// ---- testbench/spm_port_tb_top.sv ----
// Self-checking testbench for the SPI master port
`timescale 1ns/1ps
`default_nettype none
module spm_port_tb_top;
   // ------
   // Signals
   // ------
   localparam int unsigned FAULT_N = 50;
   localparam int unsigned WAIT_N = 20;
   logic clock = 1'b0, rst = 1'b1, setup_valid = 1'b0, cmd_valid = 1'b0, cmd_rx = 1'b0;
   logic mem_valid = 1'b0, mrst = 1'b1, user_sel = 1'b0, bad_idle = 1'b0;
   logic [7:0] cmd_data = 8'h00;
   spm_pkg::spm_setup_s setup_req = '0;
   spm_pkg::spm_mem_s mem_req = '0;
   logic setup_ready, port_enabled, cmd_ready, rsp_valid, mem_ready, mem_rdata_valid;
   logic mem_select_n, spi_fault, device_reset, sck_o, sck_oe, mosi, mosi_oe, miso;
   logic [7:0] rsp_data, mem_rdata;
   logic [5:0] hs;
   int err_count = 0, n_compared = 0, i, k;
   logic [12:0] rows [8] = '{13'h00A5, 13'h053C, 13'h0A81, 13'h0C7E,
      13'h1101, 13'h16C3, 13'h185A, 13'h1F96};
   assign hs = {device_reset, mem_rdata_valid, mem_ready, rsp_valid, cmd_ready, setup_ready};
   always #25 clock = ~clock;
   spm_port #(.FAULT_CYCLES(FAULT_N), .WRITE_WAIT_CYCLES(WAIT_N)) dut (.clock(clock), .rst(rst),
      .setup_valid(setup_valid), .setup_req(setup_req), .setup_ready(setup_ready),
      .port_enabled(port_enabled), .cmd_valid(cmd_valid), .cmd_rx(cmd_rx), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_valid(mem_valid),
      .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata_valid(mem_rdata_valid),
      .mem_rdata(mem_rdata), .mem_select_n(mem_select_n), .spi_fault(spi_fault),
      .device_reset(device_reset), .sck_o(sck_o), .sck_oe(sck_oe), .serial_data_out(mosi),
      .serial_data_out_oe(mosi_oe), .serial_data_in(miso));
   spm_peer_model pm (.clock(clock), .rst(mrst), .mode(setup_req.mode), .user_sel(user_sel),
      .bad_idle(bad_idle), .user_byte(8'hA5), .sck(sck_o), .select_n(mem_select_n),
      .mosi(mosi), .miso(miso));
   // ------
   // Tasks
   // ------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wt(input int s);
      int n;
      n = 0;
      while (hs[s] !== 1'b1 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 3000) chk1(1'b0, 1'b1);
   endtask
   task automatic setup(input logic off, input logic [2:0] md, input logic [1:0] sp);
      setup_req = {off, md, sp};
      setup_valid = 1'b1;
      wt(0);
      @(posedge clock);
      #1 setup_valid = 1'b0;
      mrst = 1'b1;
      repeat (3) @(posedge clock);
      #1 mrst = 1'b0;
   endtask
   task automatic xfer(input logic rx, input logic [7:0] d);
      cmd_rx = rx;
      cmd_data = d;
      cmd_valid = 1'b1;
      wt(1);
      @(posedge clock);
      #1 cmd_valid = 1'b0;
      wt(2);
      @(posedge clock);
      #1;
   endtask
   task automatic mem(input logic wr, input logic [7:0] d);
      mem_req = {wr, 16'h0005, d};
      mem_valid = 1'b1;
      wt(3);
      @(posedge clock);
      #1 mem_valid = 1'b0;
   endtask
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #3000000;
      err_count++;
      stop_test();
   end
   // ------
   // Main sequence
   // ------
   initial begin
      repeat (5) @(posedge clock);
      #1 rst = 1'b0;
      chk1(mem_select_n, 1'b1);
      chk1(sck_oe, 1'b0);
      cmd_valid = 1'b1;
      repeat (4) @(posedge clock);
      #1 chk1(cmd_ready, 1'b0);
      chk1(mem_ready, 1'b0);
      chk1(rsp_valid, 1'b0);
      cmd_valid = 1'b0;
      // Every mode and speed
      for (i = 0; i < 8; i++) begin
         setup(1'b0, rows[i][12:10], rows[i][9:8]);
         chk1(port_enabled, 1'b1);
         xfer(1'b0, rows[i][7:0]);
         chk8(pm.got_ff, rows[i][7:0]);
      end
      // Receive, then two transmits in order
      setup(1'b0, 3'h0, 2'h1);
      user_sel = 1'b1;
      xfer(1'b1, 8'h00);
      chk8(rsp_data, 8'hA5);
      user_sel = 1'b0;
      xfer(1'b0, 8'h12);
      xfer(1'b0, 8'h34);
      chk8(pm.got_prev_ff, 8'h12);
      chk8(pm.got_ff, 8'h34);
      // Late sample point on a receive, edge b
      setup(1'b0, 3'h5, 2'h1);
      user_sel = 1'b1;
      xfer(1'b1, 8'h00);
      chk8(rsp_data, 8'hA5);
      user_sel = 1'b0;
      // Memory write, wait, read back
      mem(1'b1, 8'h19);
      k = 0;
      while (mem_ready !== 1'b1 && k < 20000) begin
         @(negedge clock);
         if (mem_select_n) k++;
      end
      chk1(k >= WAIT_N, 1'b1);
      @(posedge clock);
      #1 mem(1'b0, 8'h00);
      wt(4);
      chk8(mem_rdata, 8'h19);
      // Input held off idle until device reset
      @(posedge clock);
      #1 bad_idle = 1'b1;
      repeat (3) @(posedge clock);
      #1 cmd_rx = 1'b0;
      cmd_valid = 1'b1;
      repeat (4) @(posedge clock);
      #1 chk1(cmd_ready, 1'b0);
      chk1(spi_fault, 1'b1);
      wt(5);
      @(posedge clock);
      #1 chk1(port_enabled, 1'b0);
      cmd_valid = 1'b0;
      bad_idle = 1'b0;
      // Setup off releases pins
      setup(1'b0, 3'h2, 2'h0);
      setup(1'b1, 3'h2, 2'h0);
      chk1(port_enabled, 1'b0);
      chk1(sck_oe, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
